/* File: hw/sbst_pkg.sv */
// Constants and carrier types for the SRAM boundary-scan test access port.
// Assumes a single system clock that oversamples the test clock pin.
package sbst_pkg;

  // Register lengths.
  localparam int unsigned SBST_IR_LEN = 3;
  localparam int unsigned SBST_ID_LEN = 32;
  localparam int unsigned SBST_RING_LEN = 69;

  // Identification word layout.
  localparam int unsigned SBST_ID_REV_MSB = 31;
  localparam int unsigned SBST_ID_REV_LSB = 29;
  localparam int unsigned SBST_ID_DEV_MSB = 28;
  localparam int unsigned SBST_ID_DEV_LSB = 12;
  localparam int unsigned SBST_ID_VEND_MSB = 11;
  localparam int unsigned SBST_ID_VEND_LSB = 1;
  localparam logic SBST_ID_PRESENT = 1'h1;

  // Instruction codes.
  localparam logic [2:0] SBST_EXTERNAL_TEST_INSTRUCTION = 3'h0;
  localparam logic [2:0] SBST_READ_IDENTITY_INSTRUCTION = 3'h1;
  localparam logic [2:0] SBST_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] SBST_SAMPLE_KEEP = 3'h4;
  localparam logic [2:0] SBST_BYPASS = 3'h7;

  // Pattern loaded into the instruction register during capture.
  localparam logic [2:0] SBST_IR_CAPTURE = 3'h1;

  // Values after reset.
  localparam logic [2:0] SBST_IR_RESET = SBST_READ_IDENTITY_INSTRUCTION;
  localparam logic [SBST_RING_LEN-1:0] SBST_RING_RESET = {SBST_RING_LEN{1'b0}};

  // Controller states, one-hot.
  typedef enum logic [15:0] {
    SBST_RESET = 16'h0001,
    SBST_IDLE = 16'h0002,
    SBST_SEL_DR = 16'h0004,
    SBST_CAP_DR = 16'h0008,
    SBST_SH_DR = 16'h0010,
    SBST_EX1_DR = 16'h0020,
    SBST_PAU_DR = 16'h0040,
    SBST_EX2_DR = 16'h0080,
    SBST_UPD_DR = 16'h0100,
    SBST_SEL_IR = 16'h0200,
    SBST_CAP_IR = 16'h0400,
    SBST_SH_IR = 16'h0800,
    SBST_EX1_IR = 16'h1000,
    SBST_PAU_IR = 16'h2000,
    SBST_EX2_IR = 16'h4000,
    SBST_UPD_IR = 16'h8000
  } sbst_state_type;

  // Serial link pins from the external controller.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_link_type;

endpackage : sbst_pkg

/* File: hw/sbst_tap.sv */
// Test access port of a pipelined SRAM: controller, instruction, bypass,
// identification and pin-ring registers, all on the system clock.
// Assumes the test clock is far slower than clk so its edges can be found.
`timescale 1ns/1ps
`default_nettype none

module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [2:0] REV_CODE = 3'h1, // Arbitrary value.
  parameter logic [16:0] DEVICE_CODE = 17'h0a5a5, // Arbitrary value.
  parameter logic [10:0] VENDOR_CODE = 11'h155 // Arbitrary value.
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial test pins.
  input wire sbst_link_type link,
  output logic tdo,
  output logic tdo_oe,
  // Pin ring parallel snapshot.
  input wire logic [SBST_RING_LEN-1:0] ring_in,
  // SRAM output float request.
  output logic sram_out_hiz
);

  logic [2:0] tck_sync_q;
  logic [1:0] tms_sync_q;
  logic [1:0] tdi_sync_q;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  sbst_state_type state_q;
  sbst_state_type state_d;
  logic [SBST_IR_LEN-1:0] ir_shift_q;
  logic [SBST_IR_LEN-1:0] ir_q;
  logic bypass_q;
  logic [SBST_ID_LEN-1:0] id_shift_q;
  logic [SBST_RING_LEN-1:0] ring_q;
  logic [SBST_RING_LEN-1:0] ring_meta_q;
  logic [SBST_RING_LEN-1:0] ring_sync_q;
  logic [SBST_ID_LEN-1:0] id_word;
  logic sel_ring;
  logic sel_id;
  logic serial_bit;
  logic shifting;

  // Two flops per pin; the third tck flop only feeds edge detection.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tck_sync_q <= 3'h0;
      tms_sync_q <= 2'h3;
      tdi_sync_q <= 2'h0;
    end
    else if (clk_en)
    begin
      tck_sync_q <= {tck_sync_q[1:0], link.tck};
      tms_sync_q <= {tms_sync_q[0], link.tms};
      tdi_sync_q <= {tdi_sync_q[0], link.tdi};
    end
  end

  // The pin ring snapshot crosses in through two flops like any other pin.
  // The word is not coherent while the pins move, so they must stand still around capture.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ring_meta_q <= SBST_RING_RESET;
      ring_sync_q <= SBST_RING_RESET;
    end
    else if (clk_en)
    begin
      ring_meta_q <= ring_in;
      ring_sync_q <= ring_meta_q;
    end
  end

  // TMS and TDI are sampled with the detected rising edge.
  assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
  assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
  assign tms_s = tms_sync_q[1];
  assign tdi_s = tdi_sync_q[1];

  // Identification word is hardwired; bit zero marks its presence.
  assign id_word = {REV_CODE, DEVICE_CODE, VENDOR_CODE, SBST_ID_PRESENT};

  // Data path selection by the active instruction; reserved codes fall to bypass.
  assign sel_ring = (ir_q == SBST_EXTERNAL_TEST_INSTRUCTION) || (ir_q == SBST_SAMPLE_HIZ)
                    || (ir_q == SBST_SAMPLE_KEEP);
  assign sel_id = (ir_q == SBST_READ_IDENTITY_INSTRUCTION);

  // Floating the SRAM outputs only for the two high-impedance codes.
  assign sram_out_hiz = (ir_q == SBST_EXTERNAL_TEST_INSTRUCTION) || (ir_q == SBST_SAMPLE_HIZ);

  // Next state of the controller.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SBST_RESET: state_d = tms_s ? SBST_RESET : SBST_IDLE;
      SBST_IDLE: state_d = tms_s ? SBST_SEL_DR : SBST_IDLE;
      SBST_SEL_DR: state_d = tms_s ? SBST_SEL_IR : SBST_CAP_DR;
      SBST_CAP_DR: state_d = tms_s ? SBST_EX1_DR : SBST_SH_DR;
      SBST_SH_DR: state_d = tms_s ? SBST_EX1_DR : SBST_SH_DR;
      SBST_EX1_DR: state_d = tms_s ? SBST_UPD_DR : SBST_PAU_DR;
      SBST_PAU_DR: state_d = tms_s ? SBST_EX2_DR : SBST_PAU_DR;
      SBST_EX2_DR: state_d = tms_s ? SBST_UPD_DR : SBST_SH_DR;
      SBST_UPD_DR: state_d = tms_s ? SBST_SEL_DR : SBST_IDLE;
      SBST_SEL_IR: state_d = tms_s ? SBST_RESET : SBST_CAP_IR;
      SBST_CAP_IR: state_d = tms_s ? SBST_EX1_IR : SBST_SH_IR;
      SBST_SH_IR: state_d = tms_s ? SBST_EX1_IR : SBST_SH_IR;
      SBST_EX1_IR: state_d = tms_s ? SBST_UPD_IR : SBST_PAU_IR;
      SBST_PAU_IR: state_d = tms_s ? SBST_EX2_IR : SBST_PAU_IR;
      SBST_EX2_IR: state_d = tms_s ? SBST_UPD_IR : SBST_SH_IR;
      SBST_UPD_IR: state_d = tms_s ? SBST_SEL_DR : SBST_IDLE;
      default: state_d = SBST_RESET;
    endcase
  end

  // Controller steps on each rising test clock edge; five TMS-high steps reach reset from anywhere.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= SBST_RESET;
    else if (clk_en && tck_rise)
      state_q <= state_d;
  end

  // Instruction shift and active instruction.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ir_shift_q <= SBST_IR_RESET;
      ir_q <= SBST_IR_RESET;
    end
    else if (clk_en && tck_rise)
    begin
      case (state_q)
        SBST_CAP_IR: ir_shift_q <= SBST_IR_CAPTURE;
        SBST_SH_IR: ir_shift_q <= {tdi_s, ir_shift_q[SBST_IR_LEN-1:1]};
        SBST_UPD_IR: ir_q <= ir_shift_q;
        default: ir_q <= ir_q;
      endcase
      // Reload on the very step that enters reset, so a floating code cannot linger a step.
      if (state_d == SBST_RESET)
        ir_q <= SBST_IR_RESET;
    end
  end

  // Data registers: bypass bit, identification shifter and pin ring.
  // The ring has no parallel output latch, so preload data is simply discarded.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bypass_q <= 1'h0;
      id_shift_q <= {SBST_ID_LEN{1'b0}};
      ring_q <= SBST_RING_RESET;
    end
    else if (clk_en && tck_rise)
    begin
      if (state_q == SBST_CAP_DR)
      begin
        bypass_q <= 1'h0;
        if (sel_id)
          id_shift_q <= id_word;
        if (sel_ring)
          ring_q <= ring_sync_q;
      end
      else if (state_q == SBST_SH_DR)
      begin
        if (sel_ring)
          ring_q <= {tdi_s, ring_q[SBST_RING_LEN-1:1]};
        else if (sel_id)
          id_shift_q <= {tdi_s, id_shift_q[SBST_ID_LEN-1:1]};
        else
          bypass_q <= tdi_s;
      end
    end
  end

  // Serial source: LSB of whichever register sits in the path.
  assign shifting = (state_q == SBST_SH_DR) || (state_q == SBST_SH_IR);
  assign serial_bit = (state_q == SBST_SH_IR) ? ir_shift_q[0]
                      : sel_ring ? ring_q[0]
                      : sel_id ? id_shift_q[0]
                      : bypass_q;

  // TDO moves only on the falling edge, giving the far end a half period of setup.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end
    else if (clk_en && tck_fall)
    begin
      tdo <= serial_bit;
      tdo_oe <= shifting;
    end
  end

endmodule : sbst_tap

`default_nettype wire

/* File: tb/sbst_tap_chk.sv */
// Concurrent checks on the pins of the boundary-scan port.
// Assumes each test clock phase spans several system clocks.
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_chk
  import sbst_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Observed pins.
  input wire sbst_link_type link,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic sram_out_hiz
);
  logic [2:0] ones_q;
  logic tms_rise_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Count pin rises with the mode pin high; saturating keeps the reset visible while the mode pin stays high.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ones_q <= 3'h0;
      tms_rise_q <= 1'b1;
    end
    else if ($rose(link.tck))
    begin
      tms_rise_q <= link.tms;
      ones_q <= !link.tms ? 3'h0 : (ones_q == 3'h5) ? 3'h5 : ones_q + 3'h1;
    end
  end
  reset_outs_a: assert property (disable iff (1'b0) !rst_n && clk_en |=> !tdo_oe && !sram_out_hiz)
    else $error("outputs not cleared by reset");
  reset_tdo_a: assert property (disable iff (1'b0) !rst_n && clk_en |=> !tdo)
    else $error("serial out not cleared by reset");
  tdo_fall_a: assert property ($changed(tdo) |-> !$past(link.tck))
    else $error("serial out moved away from a falling edge");
  oe_fall_a: assert property ($changed(tdo_oe) |-> !$past(link.tck))
    else $error("output enable moved away from a falling edge");
  tdo_hold_a: assert property ($changed(tdo) |=> $stable(tdo)[*8])
    else $error("serial out did not stand");
  hiz_rise_a: assert property ($changed(sram_out_hiz) && $past(rst_n) |-> $past(link.tck))
    else $error("float request moved away from a rising edge");
  tap_reset_a: assert property (ones_q == 3'h5 |-> ##[1:8] !sram_out_hiz)
    else $error("five high mode rises did not reset");
  oe_exit_a: assert property ($fell(link.tck) && tms_rise_q |-> ##5 !tdo_oe)
    else $error("output enabled outside a shift state");
  freeze_a: assert property (!clk_en |=> $stable(tdo) && $stable(tdo_oe) && $stable(sram_out_hiz))
    else $error("outputs moved while the clock enable was low");
endmodule // sbst_tap_chk
bind sbst_tap sbst_tap_chk u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .link(link), .tdo(tdo),
  .tdo_oe(tdo_oe), .sram_out_hiz(sram_out_hiz));
`default_nettype wire

/* File: tb/sbst_ctl.sv */
// Behavioural boundary-scan controller on the test pins.
// Assumes a 125 ns test clock that stands low between steps.
`timescale 1ns/1ps
`default_nettype none
module sbst_ctl
  import sbst_pkg::*;
(
  // Serial pins.
  output var sbst_link_type link,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial link = 3'h2;
  // One clock period; pins move only at the fall, so hold after the rise is kept.
  task automatic step(input logic ms, input logic di, output logic so);
    link.tms <= ms;
    link.tdi <= di;
    // An undriven line shows the inverse, so a missing output enable is caught.
    #62.5 so = tdo_oe ? tdo : ~tdo;
    link.tck <= 1'b1;
    #62.5 link.tck <= 1'b0;
  endtask
  // Full scan from idle: n bits least significant first, then update and idle.
  task automatic shift(input logic ir, input logic [68:0] di, input int n, output logic [68:0] dq);
    logic so;
    dq = '0;
    step(1'b1, 1'b0, so);
    if (ir)
      step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
    step(1'b0, 1'b0, so);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, di[i], so);
      dq[i] = so;
    end
    step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
  endtask
  // Five high mode steps from anywhere, then idle.
  task automatic park();
    logic so;
    repeat (5) step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
  endtask
endmodule // sbst_ctl
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the boundary-scan port.
// Assumes the checker is bound in and the controller model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sbst_pkg::*;
;
  typedef struct packed {logic [2:0] code; logic hiz; logic ring;} sbst_row_type;
  localparam logic [2:0] REV = 3'h5; // Arbitrary value.
  localparam logic [16:0] DEV = 17'h1c3a5; // Arbitrary value.
  localparam logic [10:0] VEND = 11'h2b6; // Arbitrary value.
  // Legal codes only, ending on a floating one so the later reset shows.
  localparam sbst_row_type ROWS [4] = '{'{3'h0, 1'b1, 1'b1}, '{3'h4, 1'b0, 1'b1}, '{3'h7, 1'b0, 1'b0},
    '{3'h2, 1'b1, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  sbst_link_type link;
  logic tdo, tdo_oe, sram_out_hiz, so;
  logic [68:0] ring_in = 69'h1_5a3c_96e1_0f87_d24b;
  logic [68:0] q;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  sbst_tap #(.REV_CODE(REV), .DEVICE_CODE(DEV), .VENDOR_CODE(VEND)) DUT (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .link(link), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .sram_out_hiz(sram_out_hiz));
  sbst_ctl u_ctl (.link(link), .tdo(tdo), .tdo_oe(tdo_oe));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [68:0] got, input logic [68:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hang is cut short well beyond the expected run of about 5200 cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  // Main sequence: identity after reset, the code table, then the awkward cases.
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(tdo_oe, 1'b0);
    chk(sram_out_hiz, 1'b0);
    u_ctl.park();
    u_ctl.shift(1'b0, '0, 32, q);
    chk(q, {REV, DEV, VEND, 1'b1});
    foreach (ROWS[i])
    begin
      @(posedge clk) ring_in <= ~ring_in;
      u_ctl.shift(1'b1, 69'(ROWS[i].code), 3, q);
      chk(q[1:0], 2'h1);
      chk(sram_out_hiz, ROWS[i].hiz);
      u_ctl.shift(1'b0, ~ring_in, ROWS[i].ring ? 69 : 8, q);
      chk(q, ROWS[i].ring ? ring_in : {61'h0, ~ring_in[6:0], 1'b0});
    end
    // Leave from the middle of a data shift with the mode pin held high.
    u_ctl.step(1'b1, 1'b0, so);
    u_ctl.step(1'b0, 1'b0, so);
    u_ctl.step(1'b0, 1'b0, so);
    u_ctl.park();
    chk(sram_out_hiz, 1'b0);
    chk(tdo_oe, 1'b0);
    u_ctl.shift(1'b0, '0, 32, q);
    chk(q, {REV, DEV, VEND, 1'b1});
    // With the clock enable low a whole instruction load must leave no trace.
    repeat (4) @(posedge clk);
    clk_en <= 1'b0;
    u_ctl.shift(1'b1, 69'h0, 3, q);
    @(posedge clk) clk_en <= 1'b1;
    chk(tdo_oe, 1'b0);
    chk(sram_out_hiz, 1'b0);
    u_ctl.shift(1'b0, '0, 32, q);
    chk(q, {REV, DEV, VEND, 1'b1});
    // A second pin reset in mid-run after loading a floating code.
    u_ctl.shift(1'b1, 69'h0, 3, q);
    chk(sram_out_hiz, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(sram_out_hiz, 1'b0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
